// ### pkg/dio_cond_pkg.sv
// Constants, register map and timing for the direct I/O conditioning block
package dio_cond_pkg;
    // Clock and timing
    localparam int CLK_HZ = 50_000_000;                  // Core clock rate
    localparam int MS_CYCLES_DEF = CLK_HZ / 1000;        // Cycles per millisecond tick
    localparam int ONE_SHOT_US = 250;                    // One-shot pulse width in us
    localparam int ONE_SHOT_CYCLES_DEF = (CLK_HZ / 1_000_000) * ONE_SHOT_US; // Rounded down, kept exact
    localparam logic [7:0] DEAD_MAX_MS = 8'hfa;          // 250 ms ceiling for ON dead-time
    localparam logic [11:0] DELAY_MAX_MS = 12'hfa0;      // 4000 ms ceiling for OFF delay

    // Lane counts and code width
    localparam int NUM_IN = 4;                           // Direct inputs
    localparam int NUM_OUT = 2;                          // Direct outputs
    localparam int NUM_CODES = 256;                      // Assignment code space

    // Special assignment codes
    localparam logic [7:0] CODE_UNUSED = 8'h00;          // Terminal not used
    localparam logic [7:0] CODE_CONST_OFF = 8'h80;       // Constant-off status source

    // Register byte offsets
    localparam logic [7:0] IN_FUNC_OFS = 8'h00;          // Input assignment codes
    localparam logic [7:0] IN_CTRL_OFS = 8'h04;          // Input invert, one-shot, composite
    localparam logic [7:0] IN_DEAD_OFS = 8'h08;          // Input ON dead-time in ms
    localparam logic [7:0] OUT_FUNC_OFS = 8'h0c;         // Output assignment codes
    localparam logic [7:0] OUT_CTRL_OFS = 8'h10;         // Output invert, combine, composite
    localparam logic [7:0] OUT_DELAY_OFS = 8'h14;        // Output OFF delay in ms
    localparam logic [7:0] STATUS_OFS = 8'h18;           // Read-only live levels

    // Field positions
    localparam int IN_INV_BIT = 0;                       // Input inversion
    localparam int IN_ONESHOT_BIT = 1;                   // One-shot enable
    localparam int IN_COMP_LSB = 8;                      // Composite input code
    localparam int OUT_INV_BIT = 0;                      // Output inversion
    localparam int OUT_OR_BIT = 1;                       // 1: OR, 0: AND
    localparam int OUT_CINV_BIT = 2;                     // Composite inversion
    localparam int OUT_COMP_LSB = 8;                     // Composite output code
    localparam int STAT_OUT_LSB = 4;                     // Output levels in status

    // Reset values
    localparam logic [7:0] IN0_FUNC_RST = 8'h48;         // 72
    localparam logic [7:0] IN1_FUNC_RST = 8'h49;         // 73
    localparam logic [7:0] IN2_FUNC_RST = 8'h05;         // 5
    localparam logic [7:0] IN3_FUNC_RST = 8'h01;         // 1
    localparam logic [7:0] OUT0_FUNC_RST = 8'hf1;        // 241
    localparam logic [7:0] OUT1_FUNC_RST = 8'h82;        // 130
    localparam logic IN_INV_RST = 1'b0;                  // Not inverted
    localparam logic IN_ONESHOT_RST = 1'b0;              // One-shot off
    localparam logic [7:0] IN_COMP_RST = 8'h00;          // Not used
    localparam logic [7:0] IN_DEAD_RST = 8'h00;          // No filtering
    localparam logic OUT_INV_RST = 1'b0;                 // Not inverted
    localparam logic OUT_OR_RST = 1'b1;                  // OR
    localparam logic OUT_CINV_RST = 1'b0;                // Not inverted
    localparam logic [7:0] OUT_COMP_RST = 8'h80;         // Constant off
    localparam logic [11:0] OUT_DELAY_RST = 12'h000;     // No OFF delay
endpackage

// ### src/direct_io_signal_conditioning.sv
// Direct input/output conditioning with an APB register file
// Notes on behaviour
// R1 - Inputs route to selected function; defaults 72,73,5,1
// R2 - One input inversion setting, reset not inverted
// R3 - Input ON only after exceeding dead-time
// R4 - One-shot returns input inactive after 250 us
// R5 - Active input also asserts composite input function
// R6 - Outputs carry selected status; defaults 241,130
// R7 - One output inversion setting, reset not inverted
// R8 - Output drops OFF after exceeding OFF delay; code drops it when the tick count reaches delay_q
// R9 - Combine code 0 AND, 1 OR, reset OR
// R10 - Output ON when combination holds; default 128
// R11 - Composite signal optionally inverted before combining
// R12 - Host must not one-shot the tool unlock input
// R13 - Code 0 drives no internal function
// R14 - Sync, invert, dead-time, one-shot, then routing
// R15 - Output invert after combine, then OFF delay
`timescale 1ns/1ps
module direct_io_signal_conditioning
    import dio_cond_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF,             // Cycles per ms tick
    parameter int ONE_SHOT_CYCLES = ONE_SHOT_CYCLES_DEF  // One-shot width in cycles
) (
    input wire logic clock,                              // 50 MHz core clock
    input wire logic sys_rst,                            // Synchronous reset, active high
    input wire logic psel,                               // APB select
    input wire logic penable,                            // APB enable
    input wire logic pwrite,                             // APB write
    input wire logic [7:0] paddr,                        // APB byte address
    input wire logic [31:0] pwdata,                      // APB write data
    output logic [31:0] prdata,                          // APB read data
    output logic pready,                                 // APB ready
    output logic pslverr,                                // APB error on unmapped
    input wire logic [NUM_IN-1:0] din,                   // Direct input pins
    output logic [NUM_CODES-1:0] func_active,            // Internal function requests
    input wire logic [NUM_CODES-1:0] status_sig,         // Internal status signals
    output logic [NUM_OUT-1:0] dout                      // Direct output pins
);

    // Pick one status signal; the constant-off code reads as zero
    function automatic logic pick(input logic [NUM_CODES-1:0] vec, input logic [7:0] code);
        logic r;
        r = vec[code];
        if (code == CODE_CONST_OFF) begin
            r = 1'b0;
        end
        return r;
    endfunction

    // Configuration registers
    logic [7:0] in_sel_q [NUM_IN];                       // Input assignment codes
    logic [7:0] in_sel_d [NUM_IN];
    logic in_inv_q, in_inv_d;                            // Input inversion
    logic oneshot_q, oneshot_d;                          // One-shot enable
    logic [7:0] in_comp_q, in_comp_d;                    // Composite input code
    logic [7:0] dead_q, dead_d;                          // Dead-time in ms
    logic [7:0] out_sel_q [NUM_OUT];                     // Output assignment codes
    logic [7:0] out_sel_d [NUM_OUT];
    logic out_inv_q, out_inv_d;                          // Output inversion
    logic out_or_q, out_or_d;                            // Combine mode
    logic cinv_q, cinv_d;                                // Composite inversion
    logic [7:0] out_comp_q, out_comp_d;                  // Composite output code
    logic [11:0] delay_q, delay_d;                       // OFF delay in ms
    logic [31:0] prdata_q, prdata_d;                     // Read data
    logic pready_q, pready_d;                            // Ready flop
    logic pslverr_q, pslverr_d;                          // Error flop

    // Datapath state
    logic [NUM_IN-1:0] sync1_q, sync2_q;                 // Two-flop input synchroniser
    logic [15:0] tick_cnt_q, tick_cnt_d;                 // Millisecond divider
    logic tick_q, tick_d;                                // One-cycle ms enable
    logic [7:0] dcnt_q [NUM_IN];                         // Dead-time counters
    logic [7:0] dcnt_d [NUM_IN];
    logic [13:0] os_cnt_q [NUM_IN];                      // One-shot counters
    logic [13:0] os_cnt_d [NUM_IN];
    logic [NUM_IN-1:0] os_done_q, os_done_d;             // One-shot already fired
    logic [NUM_IN-1:0] cond_q, cond_d;                   // Conditioned input levels
    logic [NUM_CODES-1:0] func_q, func_d;                // Routed functions
    logic [11:0] ocnt_q [NUM_OUT];                       // OFF delay counters
    logic [11:0] ocnt_d [NUM_OUT];
    logic [NUM_OUT-1:0] dout_q, dout_d;                  // Output levels

    // Register file next state and APB answer
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            in_sel_d[i] = in_sel_q[i];
        end
        for (int j = 0; j < NUM_OUT; j++) begin
            out_sel_d[j] = out_sel_q[j];
        end
        in_inv_d = in_inv_q;
        oneshot_d = oneshot_q;
        in_comp_d = in_comp_q;
        dead_d = dead_q;
        out_inv_d = out_inv_q;
        out_or_d = out_or_q;
        cinv_d = cinv_q;
        out_comp_d = out_comp_q;
        delay_d = delay_q;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        pready_d = 1'b0;
        // First access cycle: prepare answer, ready goes high one cycle later
        if (psel && penable && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = 1'b0;
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                IN_FUNC_OFS: prdata_d = {in_sel_q[3], in_sel_q[2], in_sel_q[1], in_sel_q[0]};
                IN_CTRL_OFS: begin
                    prdata_d[IN_INV_BIT] = in_inv_q;
                    prdata_d[IN_ONESHOT_BIT] = oneshot_q;
                    prdata_d[IN_COMP_LSB +: 8] = in_comp_q;
                end
                IN_DEAD_OFS: prdata_d[7:0] = dead_q;
                OUT_FUNC_OFS: prdata_d[15:0] = {out_sel_q[1], out_sel_q[0]};
                OUT_CTRL_OFS: begin
                    prdata_d[OUT_INV_BIT] = out_inv_q;
                    prdata_d[OUT_OR_BIT] = out_or_q;
                    prdata_d[OUT_CINV_BIT] = cinv_q;
                    prdata_d[OUT_COMP_LSB +: 8] = out_comp_q;
                end
                OUT_DELAY_OFS: prdata_d[11:0] = delay_q;
                STATUS_OFS: begin
                    prdata_d[NUM_IN-1:0] = cond_q;
                    prdata_d[STAT_OUT_LSB +: NUM_OUT] = dout_q;
                end
                default: pslverr_d = 1'b1;               // Unmapped address
            endcase
        end
        // Writes land on the edge where the master sees ready high
        if (psel && penable && pready_q && pwrite && !pslverr_q) begin
            unique case (paddr)
                IN_FUNC_OFS: begin
                    for (int i = 0; i < NUM_IN; i++) begin
                        in_sel_d[i] = pwdata[8*i +: 8];  // R1
                    end
                end
                IN_CTRL_OFS: begin
                    in_inv_d = pwdata[IN_INV_BIT];       // R2
                    oneshot_d = pwdata[IN_ONESHOT_BIT];
                    in_comp_d = pwdata[IN_COMP_LSB +: 8];
                end
                // Out-of-range times are clamped to their ceiling
                IN_DEAD_OFS: dead_d = (pwdata[31:0] > 32'(DEAD_MAX_MS)) ? DEAD_MAX_MS : pwdata[7:0];
                OUT_FUNC_OFS: begin
                    out_sel_d[0] = pwdata[7:0];          // R6
                    out_sel_d[1] = pwdata[15:8];
                end
                OUT_CTRL_OFS: begin
                    out_inv_d = pwdata[OUT_INV_BIT];     // R7
                    out_or_d = pwdata[OUT_OR_BIT];       // R9
                    cinv_d = pwdata[OUT_CINV_BIT];       // R11
                    out_comp_d = pwdata[OUT_COMP_LSB +: 8];
                end
                OUT_DELAY_OFS: delay_d = (pwdata[31:0] > 32'(DELAY_MAX_MS)) ? DELAY_MAX_MS : pwdata[11:0];
                default: ;                               // Read-only or unmapped
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_sel_q[0] <= IN0_FUNC_RST;                 // R1
            in_sel_q[1] <= IN1_FUNC_RST;
            in_sel_q[2] <= IN2_FUNC_RST;
            in_sel_q[3] <= IN3_FUNC_RST;
            in_inv_q <= IN_INV_RST;                      // R2
            oneshot_q <= IN_ONESHOT_RST;                 // R4
            in_comp_q <= IN_COMP_RST;                    // R5
            dead_q <= IN_DEAD_RST;                       // R3
            out_sel_q[0] <= OUT0_FUNC_RST;               // R6
            out_sel_q[1] <= OUT1_FUNC_RST;
            out_inv_q <= OUT_INV_RST;                    // R7
            out_or_q <= OUT_OR_RST;                      // R9
            cinv_q <= OUT_CINV_RST;                      // R11
            out_comp_q <= OUT_COMP_RST;                  // R10
            delay_q <= OUT_DELAY_RST;                    // R8
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            in_sel_q <= in_sel_d;
            in_inv_q <= in_inv_d;
            oneshot_q <= oneshot_d;
            in_comp_q <= in_comp_d;
            dead_q <= dead_d;
            out_sel_q <= out_sel_d;
            out_inv_q <= out_inv_d;
            out_or_q <= out_or_d;
            cinv_q <= cinv_d;
            out_comp_q <= out_comp_d;
            delay_q <= delay_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Conditioning pipeline next state
    always_comb begin
        logic act;
        logic filt;
        logic lvl;
        logic comp;
        act = 1'b0;
        filt = 1'b0;
        lvl = 1'b0;
        comp = 1'b0;
        // Millisecond enable; timing resolution is one tick
        tick_d = 1'b0;
        tick_cnt_d = tick_cnt_q + 16'h0001;
        if (tick_cnt_q == 16'(MS_CYCLES - 1)) begin
            tick_cnt_d = 16'h0000;
            tick_d = 1'b1;
        end
        func_d = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            act = sync2_q[i] ^ in_inv_q;                 // R2 R14
            // Count whole ticks spent active, saturating
            dcnt_d[i] = dcnt_q[i];
            if (!act) begin
                dcnt_d[i] = 8'h00;
            end else if (tick_q && dcnt_q[i] != 8'hff) begin
                dcnt_d[i] = dcnt_q[i] + 8'h01;
            end
            filt = act && (dead_q == 8'h00 || dcnt_q[i] > dead_q); // R3
            // One-shot arms on each rise of the filtered level
            os_done_d[i] = os_done_q[i];
            os_cnt_d[i] = os_cnt_q[i];
            if (!filt) begin
                os_done_d[i] = 1'b0;
                os_cnt_d[i] = 14'h0000;
            end else if (!os_done_q[i]) begin
                os_done_d[i] = 1'b1;
                os_cnt_d[i] = 14'(ONE_SHOT_CYCLES - 1);  // R4
            end else if (os_cnt_q[i] != 14'h0000) begin
                os_cnt_d[i] = os_cnt_q[i] - 14'h0001;
            end
            cond_d[i] = filt && (!oneshot_q || !os_done_q[i] || os_cnt_q[i] != 14'h0000); // R4 R14
            if (cond_q[i]) begin
                func_d[in_sel_q[i]] = 1'b1;              // R1
                func_d[in_comp_q] = 1'b1;                // R5
            end
        end
        func_d[CODE_UNUSED] = 1'b0;                      // R13
        for (int j = 0; j < NUM_OUT; j++) begin
            comp = pick(status_sig, out_comp_q) ^ cinv_q; // R11
            lvl = out_or_q ? (pick(status_sig, out_sel_q[j]) | comp)
                           : (pick(status_sig, out_sel_q[j]) & comp); // R9 R10
            lvl = lvl ^ out_inv_q;                       // R7 R15
            // OFF delay holds the output while ticks are counted
            ocnt_d[j] = ocnt_q[j];
            if (lvl) begin
                ocnt_d[j] = 12'h000;
            end else if (tick_q && ocnt_q[j] != 12'hfff) begin
                ocnt_d[j] = ocnt_q[j] + 12'h001;
            end
            dout_d[j] = lvl || (dout_q[j] && ocnt_q[j] < delay_q); // R8 R15
        end
    end

    // Conditioning pipeline flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            for (int i = 0; i < NUM_IN; i++) begin
                dcnt_q[i] <= 8'h00;
                os_cnt_q[i] <= 14'h0000;
            end
            os_done_q <= '0;
            cond_q <= '0;
            func_q <= '0;
            for (int j = 0; j < NUM_OUT; j++) begin
                ocnt_q[j] <= 12'h000;
            end
            dout_q <= '0;
        end else begin
            sync1_q <= din;                              // R14
            sync2_q <= sync1_q;
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            dcnt_q <= dcnt_d;
            os_cnt_q <= os_cnt_d;
            os_done_q <= os_done_d;
            cond_q <= cond_d;
            func_q <= func_d;
            ocnt_q <= ocnt_d;
            dout_q <= dout_d;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign func_active = func_q;
    assign dout = dout_q;

endmodule

// ### bench/dio_host_model.sv
// Outside controller model: drives the wired direct inputs
`timescale 1ns/1ps
module dio_host_model
    import dio_cond_pkg::*;
(
    input wire logic clock, // Core clock
    input wire logic [NUM_IN-1:0] want, // Levels asked by the test
    output logic [NUM_IN-1:0] din // Wired input pins
);
    // Pins start released low before the first edge
    initial din = '0;
    // Switch just after an edge; the block must synchronise anyway
    always @(posedge clock) begin
        din <= want;
    end
endmodule

// ### bench/dio_cond_chk.sv
// Bus and signal path checker for the direct I/O block
`timescale 1ns/1ps
module dio_cond_chk
    import dio_cond_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF, // Cycles per ms tick
    parameter int ONE_SHOT_CYCLES = ONE_SHOT_CYCLES_DEF // One-shot width
) (
    input wire logic clock, // Core clock
    input wire logic sys_rst, // Sync reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [NUM_IN-1:0] din, // Input pins
    input wire logic [NUM_CODES-1:0] func_active, // Function requests
    input wire logic [NUM_CODES-1:0] status_sig, // Status sources
    input wire logic [NUM_OUT-1:0] dout // Output pins
);
    logic [31:0] inf_q, inf_d; // Shadow input codes
    logic [15:0] icf_q, icf_d, ocf_q, ocf_d, ofn_q, ofn_d; // Shadow controls
    logic dz_q, dz_d; // OFF delay is zero
    logic [NUM_CODES-1:0] ok_d, m1_q, m2_q; // Allowed request bits, now and older
    logic [1:0] lvl; // Expected output level
    logic cmp; // Composite after inversion
    logic [NUM_CODES-1:0] src; // Sources, constant-off code forced low
    wire wr = psel && penable && pready && pwrite; // Write commits here

    // Mirror configuration; old routing kept two cycles for pipeline drain
    always_comb begin
        inf_d = inf_q;
        icf_d = icf_q;
        ofn_d = ofn_q;
        ocf_d = ocf_q;
        dz_d = dz_q;
        if (wr) begin
            case (paddr)
                IN_FUNC_OFS: inf_d = pwdata;
                IN_CTRL_OFS: icf_d = pwdata[15:0];
                OUT_FUNC_OFS: ofn_d = pwdata[15:0];
                OUT_CTRL_OFS: ocf_d = pwdata[15:0];
                OUT_DELAY_OFS: dz_d = (pwdata == 32'h0);
                default: ;
            endcase
        end
        ok_d = '0;
        for (int i = 0; i < NUM_IN; i++) ok_d[inf_q[8*i+:8]] = 1'b1;
        ok_d[icf_q[15:8]] = 1'b1;
        ok_d[0] = 1'b0; // Unused code drives nothing
        src = status_sig;
        src[CODE_CONST_OFF] = 1'b0;
        cmp = src[ocf_q[15:8]] ^ ocf_q[OUT_CINV_BIT];
        for (int i = 0; i < NUM_OUT; i++) begin
            lvl[i] = ocf_q[OUT_OR_BIT] ? (src[ofn_q[8*i+:8]] | cmp) : (src[ofn_q[8*i+:8]] & cmp);
            lvl[i] = lvl[i] ^ ocf_q[OUT_INV_BIT];
        end
    end

    // Shadow registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            inf_q <= {IN3_FUNC_RST, IN2_FUNC_RST, IN1_FUNC_RST, IN0_FUNC_RST};
            icf_q <= {IN_COMP_RST, 6'h0, IN_ONESHOT_RST, IN_INV_RST};
            ofn_q <= {OUT1_FUNC_RST, OUT0_FUNC_RST};
            ocf_q <= {OUT_COMP_RST, 5'h0, OUT_CINV_RST, OUT_OR_RST, OUT_INV_RST};
            dz_q <= 1'b1;
            m1_q <= '0;
            m2_q <= '0;
        end else begin
            inf_q <= inf_d;
            icf_q <= icf_d;
            ofn_q <= ofn_d;
            ocf_q <= ocf_d;
            dz_q <= dz_d;
            m1_q <= ok_d;
            m2_q <= m1_q;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // First access edge, still waiting
    sequence access_s;
        psel && penable && !pready;
    endsequence

    bus_wait_a: assert property (access_s |=> pready) else $error("ready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable)) else $error("ready without access");
    unmapped_err_a: assert property (pready && paddr > STATUS_OFS |-> pslverr) else $error("no error on unmapped");
    mapped_ok_a: assert property (pready && paddr[1:0] == 2'h0 && paddr <= STATUS_OFS |-> !pslverr)
        else $error("error on mapped register");
    err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
    unused_code_a: assert property (func_active[0] == 1'b0) else $error("code zero requested");
    func_route_a: assert property ((func_active & ~(ok_d | m1_q | m2_q)) == '0)
        else $error("request on unselected code");
    out_path_a: assert property (dz_q |=> dout == $past(lvl))
        else $error("output level wrong");
endmodule

bind direct_io_signal_conditioning dio_cond_chk #(.MS_CYCLES(MS_CYCLES), .ONE_SHOT_CYCLES(ONE_SHOT_CYCLES)) chk_i (
    .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .din,
    .func_active, .status_sig, .dout);

// ### bench/testbench.sv
// Self-checking testbench for the direct I/O conditioning block
`timescale 1ns/1ps
module testbench;
    import dio_cond_pkg::*;
    localparam int MSC = 10; // Short ms tick
    localparam int OSC = 8; // Short one-shot
    logic clock = 1'b0; // Core clock
    logic sys_rst = 1'b1; // Sync reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    logic [7:0] paddr = 8'h00; // APB address
    logic [31:0] pwdata = 32'h0, prdata, rd; // APB data
    logic pready, pslverr, er; // APB answer
    logic [NUM_IN-1:0] want = '0, din; // Input levels
    logic [NUM_CODES-1:0] func_active, status_sig = '0; // Requests and sources
    logic [NUM_OUT-1:0] dout; // Output pins
    int n_fail = 0, n_checks = 0; // Tallies
    int cnt; // Scratch counter

    direct_io_signal_conditioning #(.MS_CYCLES(MSC), .ONE_SHOT_CYCLES(OSC)) dut (.clock(clock), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .din(din), .func_active(func_active), .status_sig(status_sig),
        .dout(dout));
    dio_host_model host (.clock(clock), .want(want), .din(din));

    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end

    // One transfer; request held until ready is seen, bounded wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) n_fail++; // A wait that runs out counts as a mismatch
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compare and tally
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    // Single exit point
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        tick(20000);
        n_fail++;
        conclude();
    end

    // Test sequence
    initial begin
        logic [7:0] ra [7];
        logic [31:0] rv [7];
        logic e;
        ra = '{IN_FUNC_OFS, IN_CTRL_OFS, IN_DEAD_OFS, OUT_FUNC_OFS, OUT_CTRL_OFS, OUT_DELAY_OFS, 8'h1c};
        rv = '{{IN3_FUNC_RST, IN2_FUNC_RST, IN1_FUNC_RST, IN0_FUNC_RST}, 32'h0, 32'h0,
            {16'h0, OUT1_FUNC_RST, OUT0_FUNC_RST}, 32'h8002, 32'h0, 32'h0};
        tick(5);
        sys_rst <= 1'b0;
        // Reset values, unmapped place last
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
            chk(er, i == 6);
        end
        xfer(1'b1, IN_DEAD_OFS, 32'h12c);
        xfer(1'b0, IN_DEAD_OFS, 32'h0);
        chk(rd, 32'hfa);
        xfer(1'b1, OUT_DELAY_OFS, 32'h1388);
        xfer(1'b0, OUT_DELAY_OFS, 32'h0);
        chk(rd, 32'hfa0);
        xfer(1'b1, IN_DEAD_OFS, 32'h0);
        xfer(1'b1, OUT_DELAY_OFS, 32'h0);
        done("registers");
        // Routing, unused code, inversion, composite
        want <= 4'h1;
        tick(8);
        chk(func_active[72], 1'b1);
        chk(func_active[73], 1'b0);
        xfer(1'b1, IN_FUNC_OFS, 32'h01054900);
        tick(8);
        chk(func_active[72], 1'b0);
        want <= 4'h0;
        xfer(1'b1, IN_CTRL_OFS, 32'h1);
        tick(8);
        chk(func_active[5], 1'b1);
        chk(func_active[0], 1'b0);
        xfer(1'b1, IN_CTRL_OFS, 32'h2000);
        want <= 4'h4;
        tick(8);
        chk({func_active[5], func_active[32]}, 2'h3);
        xfer(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h4);
        want <= 4'h0;
        tick(8);
        chk(func_active[32], 1'b0);
        xfer(1'b1, IN_CTRL_OFS, 32'h0);
        xfer(1'b1, IN_FUNC_OFS, rv[0]);
        done("routing");
        // Dead-time of 3 ms on input 3
        xfer(1'b1, IN_DEAD_OFS, 32'h3);
        want <= 4'h8;
        tick(25);
        chk(func_active[1], 1'b0);
        tick(25);
        chk(func_active[1], 1'b1);
        want <= 4'h0;
        xfer(1'b1, IN_DEAD_OFS, 32'h0);
        // One-shot; no input carries the tool unlock code here
        xfer(1'b1, IN_CTRL_OFS, 32'h2);
        want <= 4'h8;
        cnt = 0;
        repeat (40) begin
            @(posedge clock);
            if (func_active[1] === 1'b1) cnt++;
        end
        chk(cnt, OSC);
        want <= 4'h0;
        xfer(1'b1, IN_CTRL_OFS, 32'h0);
        done("input timing");
        // Every combine, composite inversion and output inversion
        for (int k = 0; k < 32; k++) begin
            if (k % 4 == 0) xfer(1'b1, OUT_CTRL_OFS, {16'h0, 8'hc8, 5'h0, k[4], k[3], k[2]});
            status_sig[241] <= k[0];
            status_sig[130] <= k[0];
            status_sig[200] <= k[1];
            tick(3);
            e = (k[3] ? (k[0] | (k[1] ^ k[4])) : (k[0] & (k[1] ^ k[4]))) ^ k[2];
            chk(dout, {e, e});
        end
        done("output combine");
        // OFF delay of 2 ms
        xfer(1'b1, OUT_CTRL_OFS, 32'h8002);
        xfer(1'b1, OUT_DELAY_OFS, 32'h2);
        status_sig[241] <= 1'b1;
        status_sig[128] <= 1'b1; // Constant-off code must still read low
        tick(4);
        chk(dout[0], 1'b1);
        status_sig[241] <= 1'b0;
        cnt = 0;
        repeat (40) begin
            @(posedge clock);
            if (dout[0] === 1'b1) cnt++;
        end
        chk(cnt >= MSC && cnt <= 2 * MSC + 2, 1'b1);
        done("off delay");
        conclude();
    end
endmodule
